/* mrf_ctrl.sv */
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "mrf_regs.svh"

module mrf_ctrl (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // apb slave
  input  wire mrf_pkg::mrf_apb_req_t apbReq,
  output logic               [31:0] prdata,
  output logic                      pready,
  output logic                      pslverr,
  // address filter tables
  input  wire logic          [47:0] stationAddr,
  input  wire logic          [63:0] hashTable,
  // receive stream from the phy side
  input  wire logic                 rxInValid,
  input  wire mrf_pkg::mrf_beat_t   rxIn,
  input  wire logic                 wakeFrameHit,
  // receive stream to the host side
  output logic                      rxOutValid,
  output var mrf_pkg::mrf_obeat_t   rxOut,
  output logic                      rxOutDrop,
  // transmit retry control
  input  wire logic                 txStart,
  input  wire logic                 txCollision,
  input  wire logic                 txLateCollision,
  input  wire logic                 txDone,
  output logic                      txRetry,
  output logic                      txAbort,
  output var mrf_pkg::mrf_txstat_t  txStatus,
  // events
  output logic                      wakeEvent,
  output logic                      irq
);
  import mrf_pkg::*;

  localparam logic [9:0] ADDR_CTRL = {`MRF_MAC_CONTROL_IDX, 2'b00};
  localparam logic [9:0] ADDR_WAKE = {`MRF_WAKE_CTRL_IDX, 2'b00};
  localparam logic [9:0] ADDR_STAT = {`MRF_IRQ_STATUS_IDX, 2'b00};
  localparam logic [9:0] ADDR_MASK = {`MRF_IRQ_MASK_IDX, 2'b00};

  mrf_state_t  state_ff;
  mrf_state_t  nxt_state;
  logic  [5:0] hashIdx;
  logic        apbSetup;
  logic        apbAccess;
  logic        mapped;
  logic [31:0] rdMux;
  logic  [3:0] events;
  logic  [3:0] rdClear;
  logic        rxFirst;
  logic [15:0] rxPos;
  mrf_cfg_t    rxCfgNow;
  logic        inDa;
  logic        bcastV;
  logic        exactV;
  logic        mcastV;
  logic        rejectV;
  logic        hashHit;
  logic        accept;
  logic [15:0] lenField;
  logic        trimmed;
  logic        deliver;
  logic  [4:0] nxtAttempts;
  logic        lateAbort;
  logic        retryErr;

  mrf_hash u_hash (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .byteValid (rxInValid),
    .byteFirst (rxIn.sof),
    .byteData  (rxIn.data),
    .hashIdx   (hashIdx)
  );

  function automatic logic [31:0] ctrlWord(input mrf_cfg_t c);
    logic [31:0] w;
    w = 32'h00000000;
    w[`MRF_HASH_ONLY_BIT]     = c.hashOnly;
    w[`MRF_HASH_SEL_BIT]      = c.hashSel;
    w[`MRF_LATE_RETRY_BIT]    = c.lateRetry;
    w[`MRF_BROADCAST_REJECT_REJECT_BIT]  = c.bcastReject;
    w[`MRF_RETRY_DISABLE_BIT] = c.retryDisable;
    w[`MRF_PAD_STRIP_BIT]     = c.padStrip;
    return w;
  endfunction

  always_comb begin
    nxt_state = state_ff;
    events    = 4'h0;
    rdClear   = 4'h0;

    // apb decode; zero wait states, read data captured in the setup cycle
    apbSetup  = apbReq.psel && !apbReq.penable;
    apbAccess = apbReq.psel && apbReq.penable;
    mapped    = 1'b1;
    rdMux     = 32'h00000000;
    if (apbReq.paddr == ADDR_CTRL) begin
      rdMux = ctrlWord(state_ff.ctrl);
    end else if (apbReq.paddr == ADDR_WAKE) begin
      rdMux[`MRF_WAKE_EN_BIT] = state_ff.wakeEn;
    end else if (apbReq.paddr == ADDR_STAT) begin
      rdMux[`MRF_IRQ_W-1:0] = state_ff.irqStat;
    end else if (apbReq.paddr == ADDR_MASK) begin
      rdMux[`MRF_IRQ_W-1:0] = state_ff.irqMask;
    end else begin
      mapped = 1'b0;
    end
    if (apbSetup) begin
      nxt_state.prdata = rdMux;
    end
    if (apbAccess && apbReq.pwrite) begin
      if (apbReq.paddr == ADDR_CTRL) begin
        nxt_state.ctrl.hashOnly     = apbReq.pwdata[`MRF_HASH_ONLY_BIT];
        nxt_state.ctrl.hashSel      = apbReq.pwdata[`MRF_HASH_SEL_BIT];
        nxt_state.ctrl.lateRetry    = apbReq.pwdata[`MRF_LATE_RETRY_BIT];
        nxt_state.ctrl.bcastReject  = apbReq.pwdata[`MRF_BROADCAST_REJECT_REJECT_BIT];
        nxt_state.ctrl.retryDisable = apbReq.pwdata[`MRF_RETRY_DISABLE_BIT];
        nxt_state.ctrl.padStrip     = apbReq.pwdata[`MRF_PAD_STRIP_BIT];
      end else if (apbReq.paddr == ADDR_WAKE) begin
        nxt_state.wakeEn = apbReq.pwdata[`MRF_WAKE_EN_BIT];
      end else if (apbReq.paddr == ADDR_MASK) begin
        nxt_state.irqMask = apbReq.pwdata[`MRF_IRQ_W-1:0];
      end
    end
    // clear only what the read reported, so an event after the capture survives
    if (apbAccess && !apbReq.pwrite && apbReq.paddr == ADDR_STAT) begin
      rdClear = state_ff.prdata[`MRF_IRQ_W-1:0];
    end

    // receive path
    nxt_state.outValid  = 1'b0;
    nxt_state.outDrop   = 1'b0;
    nxt_state.wakeEvent = 1'b0;
    rxFirst  = rxIn.sof;
    rxPos    = rxFirst ? 16'h0000 : state_ff.rxCnt;
    rxCfgNow = rxFirst ? state_ff.ctrl : state_ff.rxCfg;
    inDa     = rxPos <= `MRF_DA_LAST;
    bcastV   = (rxFirst || state_ff.broadcast_reject) && (!inDa || rxIn.data == `MRF_BROADCAST_REJECT_BYTE);
    exactV   = (rxFirst || state_ff.exact) && (!inDa || rxIn.data == stationAddr[{rxPos[2:0], 3'b000} +: 8]);
    mcastV   = rxFirst ? rxIn.data[0] : state_ff.mcast;
    rejectV  = rxFirst ? 1'b0 : state_ff.reject;
    hashHit  = hashTable[hashIdx];
    lenField = {state_ff.lenHi, rxIn.data};
    accept   = exactV;
    if (bcastV) begin
      accept = !rxCfgNow.bcastReject;
    end else if (mcastV) begin
      accept = rxCfgNow.hashSel ? hashHit : exactV;
    end else if (rxCfgNow.hashSel && rxCfgNow.hashOnly) begin
      accept = hashHit;
    end
    if (rxPos == `MRF_DA_LAST) begin
      rejectV = !accept;
    end
    // runts that end before the address is complete are forwarded, then flagged as dropped on an empty last beat
    if (rxIn.eof && rxPos < `MRF_DA_LAST) begin
      rejectV = 1'b1;
    end
    trimmed = !rxFirst && state_ff.trimOn && rxPos >= state_ff.trimEnd;
    deliver = (!rejectV && !trimmed) || rxIn.eof;

    if (rxInValid && (rxFirst || state_ff.rxState != RX_IDLE)) begin
      nxt_state.rxCfg  = rxCfgNow;
      nxt_state.broadcast_reject  = bcastV;
      nxt_state.exact  = exactV;
      nxt_state.mcast  = mcastV;
      nxt_state.reject = rejectV;
      nxt_state.rxCnt  = (rxPos == 16'hffff) ? rxPos : rxPos + 16'd1;
      nxt_state.rxState = (rxPos < `MRF_LEN_LO_POS) ? RX_HDR : RX_BODY;
      if (rxFirst) begin
        nxt_state.trimOn = 1'b0;
      end
      if (rxPos == `MRF_LEN_HI_POS) begin
        nxt_state.lenHi = rxIn.data;
      end
      if (rxPos == `MRF_LEN_LO_POS) begin
        nxt_state.trimOn  = rxCfgNow.padStrip && lenField < `MRF_MIN_PAYLOAD;
        nxt_state.trimEnd = `MRF_HDR_LEN + lenField;
      end
      nxt_state.outValid      = deliver;
      nxt_state.outBeat.sof   = rxIn.sof;
      nxt_state.outBeat.eof   = rxIn.eof;
      nxt_state.outBeat.empty = rejectV || trimmed;
      nxt_state.outBeat.data  = rxIn.data;
      nxt_state.outDrop       = rxIn.eof && rejectV;
      if (rxIn.eof) begin
        nxt_state.rxState = RX_IDLE;
        events[`MRF_IRQ_RX_DROP_BIT] = rejectV;
        // wake does not look at the broadcast filter
        if (state_ff.wakeEn && wakeFrameHit) begin
          nxt_state.wakeEvent = 1'b1;
          events[`MRF_IRQ_WAKE_BIT] = 1'b1;
        end
      end
    end

    // transmit retry policy
    nxt_state.txRetry      = 1'b0;
    nxt_state.txAbort      = 1'b0;
    nxt_state.txStat.valid = 1'b0;
    nxtAttempts = state_ff.attempts + 5'd1;
    lateAbort   = txLateCollision && !state_ff.txCfg.lateRetry;
    retryErr    = state_ff.txCfg.retryDisable || state_ff.attempts == `MRF_MAX_ATTEMPTS;
    case (state_ff.txState)
      TX_IDLE: begin
        if (txStart) begin
          nxt_state.txState  = TX_BUSY;
          nxt_state.txCfg    = state_ff.ctrl;
          nxt_state.attempts = 5'd1;
          nxt_state.lateSeen = 1'b0;
        end
      end
      TX_BUSY: begin
        if (txCollision) begin
          events[`MRF_IRQ_LATE_COLL_BIT] = txLateCollision;
          if (lateAbort || retryErr) begin
            nxt_state.txState              = TX_IDLE;
            nxt_state.txAbort              = 1'b1;
            nxt_state.txStat.valid         = 1'b1;
            nxt_state.txStat.lateCollision = state_ff.lateSeen || txLateCollision;
            nxt_state.txStat.retryError    = retryErr;
            nxt_state.txStat.attempts      = state_ff.attempts;
            events[`MRF_IRQ_RETRY_ERR_BIT] = retryErr;
          end else begin
            nxt_state.txRetry  = 1'b1;
            nxt_state.attempts = nxtAttempts;
            nxt_state.lateSeen = state_ff.lateSeen || txLateCollision;
          end
        end else if (txDone) begin
          nxt_state.txState              = TX_IDLE;
          nxt_state.txStat.valid         = 1'b1;
          nxt_state.txStat.lateCollision = state_ff.lateSeen;
          nxt_state.txStat.retryError    = 1'b0;
          nxt_state.txStat.attempts      = state_ff.attempts;
        end
      end
      default: begin
        nxt_state.txState = TX_IDLE;
      end
    endcase

    // set wins over the read clear
    nxt_state.irqStat = (state_ff.irqStat & ~rdClear) | events;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_ff          <= '0;
      state_ff.ctrl     <= `MRF_CTRL_RESET;
      state_ff.wakeEn   <= `MRF_WAKE_EN_RESET;
      state_ff.irqStat  <= `MRF_IRQ_RESET;
      state_ff.irqMask  <= `MRF_IRQ_RESET;
      state_ff.rxState  <= RX_IDLE;
      state_ff.txState  <= TX_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata     = state_ff.prdata;
  assign pready     = 1'b1;
  assign pslverr    = apbAccess && !mapped;
  assign rxOutValid = state_ff.outValid;
  assign rxOut      = state_ff.outBeat;
  assign rxOutDrop  = state_ff.outDrop;
  assign txRetry    = state_ff.txRetry;
  assign txAbort    = state_ff.txAbort;
  assign txStatus   = state_ff.txStat;
  assign wakeEvent  = state_ff.wakeEvent;
  assign irq        = |(state_ff.irqStat & state_ff.irqMask);

endmodule

`default_nettype wire

/* mrf_ctrl_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module mrf_ctrl_chk (
  // watched ports
  input wire logic                 core_clk,
  input wire logic                 nrst,
  input wire logic                 rxInValid,
  input wire mrf_pkg::mrf_beat_t   rxIn,
  input wire logic                 wakeFrameHit,
  input wire logic                 rxOutValid,
  input wire mrf_pkg::mrf_obeat_t  rxOut,
  input wire logic                 rxOutDrop,
  input wire logic                 txCollision,
  input wire logic                 txLateCollision,
  input wire logic                 txDone,
  input wire logic                 txRetry,
  input wire logic                 txAbort,
  input wire mrf_pkg::mrf_txstat_t txStatus,
  input wire logic                 wakeEvent
);
  import mrf_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sof_pass_a: assert property (rxInValid && rxIn.sof |=> rxOutValid && rxOut.sof)
    else $error("frame start not forwarded");
  byte_pass_a: assert property (rxOutValid && !rxOut.empty |->
    $past(rxInValid) && rxOut.data == $past(rxIn.data))
    else $error("forwarded byte differs");
  empty_eof_a: assert property (rxOutValid && rxOut.empty |-> rxOut.eof)
    else $error("empty beat before frame end");
  drop_eof_a: assert property (rxOutDrop |-> rxOutValid && rxOut.eof && $past(rxIn.eof))
    else $error("drop flag off frame end");
  late_rec_a: assert property (txStatus.valid && $past(txCollision) && $past(txLateCollision) |->
    txStatus.lateCollision)
    else $error("late collision not recorded");
  abort_stat_a: assert property (txAbort |-> txStatus.valid && $past(txCollision))
    else $error("abort without status");
  retry_cause_a: assert property (txRetry |-> $past(txCollision) && !txStatus.valid && !txAbort)
    else $error("retry without collision");
  attempt_cap_a: assert property (txStatus.valid |-> txStatus.attempts inside {[5'd1:5'd16]})
    else $error("attempt count out of range");
  done_ok_a: assert property (txStatus.valid && !txAbort |-> $past(txDone) && !txStatus.retryError)
    else $error("bad completion status");
  wake_src_a: assert property (wakeEvent |-> $past(rxInValid) && $past(rxIn.eof) && $past(wakeFrameHit))
    else $error("wake without wake frame");
endmodule
bind mrf_ctrl mrf_ctrl_chk mrf_ctrl_chk_i (.core_clk, .nrst, .rxInValid, .rxIn, .wakeFrameHit, .rxOutValid, .rxOut,
  .rxOutDrop, .txCollision, .txLateCollision, .txDone, .txRetry, .txAbort, .txStatus, .wakeEvent);
`default_nettype wire

/* mrf_ctrl_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mrf_regs.svh"
module mrf_ctrl_test;
  import mrf_pkg::*;
  localparam int         LIMIT = 40000;
  localparam logic [9:0] CTL   = {`MRF_MAC_CONTROL_IDX, 2'b00};
  localparam logic [9:0] WAK   = {`MRF_WAKE_CTRL_IDX, 2'b00};
  localparam logic [9:0] IST   = {`MRF_IRQ_STATUS_IDX, 2'b00};
  localparam logic [9:0] MSK   = {`MRF_IRQ_MASK_IDX, 2'b00};
  logic         core_clk, nrst, pready, pslverr, rxInValid, wakeFrameHit, rxOutValid, rxOutDrop;
  logic         txStart, txCollision, txLateCollision, txDone, txRetry, txAbort, wakeEvent, irq;
  logic         hit, ok, late, ab, er, fin, sl;
  logic [31:0]  prdata, rd;
  logic [47:0]  stationAddr;
  logic [63:0]  hashTable;
  logic [3:0]   m;
  logic [11:0]  outq[$];
  logic [9:0]   txExp;
  mrf_apb_req_t apbReq;
  mrf_beat_t    rxIn;
  mrf_obeat_t   rxOut;
  mrf_txstat_t  txStatus;
  mrf_cfg_t     c, nc;
  int           err_count = 0, compares = 0, cycles = 0, seed, n, ev;
  int           lens[5] = '{0, 10, 45, 46, 100};

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  mrf_ctrl mrf_ctrl_i (.core_clk, .nrst, .apbReq, .prdata, .pready, .pslverr, .stationAddr, .hashTable,
    .rxInValid, .rxIn, .wakeFrameHit, .rxOutValid, .rxOut, .rxOutDrop, .txStart, .txCollision,
    .txLateCollision, .txDone, .txRetry, .txAbort, .txStatus, .wakeEvent, .irq);
  mrf_phy_model mrf_phy_model_i (.core_clk, .rxInValid, .rxIn, .wakeFrameHit, .txCollision, .txLateCollision,
    .txDone);

  task automatic close_out();
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_rx(input logic [11:0] g, input logic [11:0] e);
    chk_reg({20'h0, g}, {20'h0, e});
  endtask
  task automatic chk_tx(input logic [9:0] g, input logic [9:0] e);
    chk_reg({22'h0, g}, {22'h0, e});
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (rxOutValid === 1'b1)
      outq.push_back({rxOutDrop, rxOut.sof, rxOut.eof, rxOut.empty, rxOut.empty ? 8'h00 : rxOut.data});
    if (cycles == LIMIT) begin
      err_count++;
      close_out();
    end
  end

  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    apbReq <= '0;
    @(posedge core_clk);
  endtask

  function automatic logic [31:0] cw(input mrf_cfg_t x);
    cw = '0;
    cw[`MRF_HASH_ONLY_BIT]     = x.hashOnly;
    cw[`MRF_HASH_SEL_BIT]      = x.hashSel;
    cw[`MRF_LATE_RETRY_BIT]    = x.lateRetry;
    cw[`MRF_BROADCAST_REJECT_REJECT_BIT]  = x.bcastReject;
    cw[`MRF_RETRY_DISABLE_BIT] = x.retryDisable;
    cw[`MRF_PAD_STRIP_BIT]     = x.padStrip;
  endfunction

  function automatic logic [5:0] hidx(input logic [7:0] f[$]);
    logic [31:0] r;
    r = `MRF_CRC_INIT;
    for (int i = 0; i < 6; i++) begin
      r ^= {24'h0, f[i]};
      repeat (8) r = r[0] ? (r >> 1) ^ `MRF_CRC_POLY : r >> 1;
    end
    hidx = r[31:26];
  endfunction

  // kind: 0 station, 1 broadcast, 2 random multicast, 3 random unicast
  task automatic rx_frame(input mrf_cfg_t x, input int kind, input int len, input int slow);
    logic [7:0]  f[$];
    logic [47:0] da;
    logic        keep;
    int          last;
    da = 48'({$random(seed), $random(seed)});
    case (kind)
      0: da = stationAddr;
      1: da = '1;
      2: da[0] = 1'b1;
      default: da[0] = 1'b0;
    endcase
    hit = kind == 1 && 1'($random(seed));
    for (int i = 0; i < 6; i++) f.push_back(da[8 * i +: 8]);
    repeat (6) f.push_back(8'($random(seed)));
    f.push_back(8'(len >> 8));
    f.push_back(8'(len));
    repeat ((len < 46 ? 46 : len) + 4) f.push_back(8'($random(seed)));
    if (da == '1) ok = !x.bcastReject;
    else if (x.hashSel && (da[0] || x.hashOnly)) ok = hashTable[hidx(f)];
    else ok = da == stationAddr;
    outq.delete();
    mrf_phy_model_i.send(f, hit, slow);
    repeat (4) @(posedge core_clk);
    last = f.size() - 1;
    foreach (f[i]) begin
      keep = ok ? !(x.padStrip && len < 46 && i >= 14 + len) : i < 5;
      if (keep || i == last)
        chk_rx(outq.pop_front(), {!ok && i == last, i == 0, i == last, !keep, keep ? f[i] : 8'h00});
    end
    chk_reg(32'(outq.size()), 32'h0);
  endtask

  initial begin
    seed = 32'h66efb71e;
    nrst <= 1'b0;
    txStart <= 1'b0;
    apbReq <= '0;
    stationAddr = 48'({$random(seed), $random(seed)});
    hashTable = {$random(seed), $random(seed)};
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    apb(0, CTL, 32'h0);
    chk_reg(rd, 32'h0);
    apb(1, CTL, '1);
    apb(0, CTL, 32'h0);
    chk_reg(rd, cw('1));
    apb(0, 10'h3fc, 32'h0);
    chk_reg({rd[30:0], sl}, 32'h1);
    apb(1, WAK, 32'h1 << `MRF_WAKE_EN_BIT);
    c = '0;
    apb(1, CTL, 32'h0);
    // the next setting is written while a frame is in flight; it must wait for the next start
    for (int k = 0; k < 60; k++) begin
      nc = mrf_cfg_t'($random(seed));
      m = 4'($random(seed));
      fork
        rx_frame(c, k % 4, lens[k % 5], k % 3);
        begin
          apb(1, CTL, cw(nc));
          apb(1, MSK, {28'h0, m});
        end
      join
      chk_reg({31'h0, irq}, {31'h0, |({hit, 2'b00, !ok} & m)});
      apb(0, IST, 32'h0);
      chk_reg(rd, {28'h0, hit, 2'b00, !ok});
      c = nc;
    end
    for (int k = 0; k < 40; k++) begin
      c = mrf_cfg_t'($random(seed));
      apb(1, CTL, cw(c));
      txStart <= 1'b1;
      @(posedge core_clk);
      txStart <= 1'b0;
      n = 1;
      late = 1'b0;
      fin = 1'b0;
      while (!fin) begin
        ev = (k % 4 == 0) ? 1 : 2'($random(seed)) % 3;
        mrf_phy_model_i.attempt(ev, k % 3);
        @(posedge core_clk);
        late |= ev == 2;
        ab = ev != 0 && ((ev == 2 && !c.lateRetry) || c.retryDisable || n == 16);
        er = ev != 0 && (c.retryDisable || n == 16);
        fin = ev == 0 || ab;
        txExp = {!fin, ab, fin, fin ? {late, er, 5'(n)} : 7'h0};
        chk_tx({txRetry, txAbort, txStatus & {1'b1, {7{fin}}}}, txExp);
        n++;
      end
      apb(0, IST, 32'h0);
      chk_reg(rd & 32'h4, {29'h0, er, 2'b00});
    end
    close_out();
  end
endmodule
`default_nettype wire

/* mrf_hash.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mrf_regs.svh"

module mrf_hash (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // byte stream
  input  wire logic       byteValid,
  input  wire logic       byteFirst,
  input  wire logic [7:0] byteData,
  // hash over the bytes so far, current byte included
  output logic      [5:0] hashIdx
);
  import mrf_pkg::*;

  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;
  logic [31:0] crcIn;

  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? `MRF_CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction

  // combinational through the current byte, so the caller sees the hash on the last address byte
  always_comb begin
    crcIn   = byteFirst ? `MRF_CRC_INIT : crc_ff;
    nxt_crc = byteValid ? crcByte(crcIn, byteData) : crc_ff;
    hashIdx = nxt_crc[`MRF_HASH_LSB +: 6];
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      crc_ff <= `MRF_CRC_INIT;
    end else begin
      crc_ff <= nxt_crc;
    end
  end

endmodule

`default_nettype wire

/* mrf_phy_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mrf_phy_model (
  // clock
  input  wire logic              core_clk,
  // receive beats towards the mac
  output logic                   rxInValid,
  output var mrf_pkg::mrf_beat_t rxIn,
  output logic                   wakeFrameHit,
  // outcome of a transmit attempt
  output logic                   txCollision,
  output logic                   txLateCollision,
  output logic                   txDone
);
  import mrf_pkg::*;
  logic [9:0] q[$];
  int         gapLen;
  int         gapCnt;
  initial begin
    {rxInValid, rxIn, wakeFrameHit, txCollision, txLateCollision, txDone} <= '0;
    gapLen = 0;
    gapCnt <= 0;
  end
  // a frame is queued whole; gapLen idle cycles between beats models a slow line
  task automatic send(input logic [7:0] f[$], input logic hit, input int slow);
    gapLen = slow;
    wakeFrameHit <= hit;
    foreach (f[i]) q.push_back({i == 0, i == f.size() - 1, f[i]});
    while (q.size() != 0) @(posedge core_clk);
  endtask
  // idle data flips every cycle so a stale byte never looks current
  always @(posedge core_clk) begin
    if (q.size() != 0 && gapCnt == 0) begin
      rxInValid <= 1'b1;
      rxIn      <= mrf_beat_t'(q.pop_front());
      gapCnt    <= gapLen;
    end else begin
      rxInValid <= 1'b0;
      rxIn.data <= ~rxIn.data;
      gapCnt    <= (gapCnt == 0) ? 0 : gapCnt - 1;
    end
  end
  // kind 0 sent, 1 collision, 2 late collision
  task automatic attempt(input int kind, input int dly);
    repeat (dly) @(posedge core_clk);
    txCollision     <= kind != 0;
    txLateCollision <= kind == 2;
    txDone          <= kind == 0;
    @(posedge core_clk);
    {txCollision, txLateCollision, txDone} <= 3'b000;
  endtask
endmodule
`default_nettype wire

/* mrf_pkg.sv */
package mrf_pkg;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_HDR  = 2'b01,
    RX_BODY = 2'b11
  } mrf_rx_state_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_BUSY = 1'b1
  } mrf_tx_state_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata;
  } mrf_apb_req_t;

  typedef struct packed {
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } mrf_beat_t;

  typedef struct packed {
    logic       sof;
    logic       eof;
    logic       empty;
    logic [7:0] data;
  } mrf_obeat_t;

  typedef struct packed {
    logic hashOnly;
    logic hashSel;
    logic lateRetry;
    logic bcastReject;
    logic retryDisable;
    logic padStrip;
  } mrf_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       lateCollision;
    logic       retryError;
    logic [4:0] attempts;
  } mrf_txstat_t;

  typedef struct packed {
    mrf_cfg_t      ctrl;
    logic          wakeEn;
    logic [3:0]    irqStat;
    logic [3:0]    irqMask;
    logic [31:0]   prdata;
    mrf_rx_state_t rxState;
    mrf_cfg_t      rxCfg;
    logic [15:0]   rxCnt;
    logic          broadcast_reject;
    logic          mcast;
    logic          exact;
    logic          reject;
    logic [7:0]    lenHi;
    logic          trimOn;
    logic [15:0]   trimEnd;
    logic          outValid;
    mrf_obeat_t    outBeat;
    logic          outDrop;
    logic          wakeEvent;
    mrf_tx_state_t txState;
    mrf_cfg_t      txCfg;
    logic [4:0]    attempts;
    logic          lateSeen;
    logic          txRetry;
    logic          txAbort;
    mrf_txstat_t   txStat;
  } mrf_state_t;

endpackage

/* mrf_regs.svh */
`ifndef MRF_REGS_SVH
`define MRF_REGS_SVH

// register indices; byte address is four times the index
`define MRF_MAC_CONTROL_IDX     8'h01
`define MRF_WAKE_CTRL_IDX       8'h0c
`define MRF_IRQ_STATUS_IDX      8'h10
`define MRF_IRQ_MASK_IDX        8'h11
`define MRF_ADDR_W              10

// mac_control field positions
`define MRF_HASH_ONLY_BIT       15
`define MRF_HASH_SEL_BIT        13
`define MRF_LATE_RETRY_BIT      12
`define MRF_BROADCAST_REJECT_REJECT_BIT    11
`define MRF_RETRY_DISABLE_BIT   10
`define MRF_PAD_STRIP_BIT       8

// wake_control_status field positions
`define MRF_WAKE_EN_BIT         2

// interrupt status / mask bits
`define MRF_IRQ_RX_DROP_BIT     0
`define MRF_IRQ_LATE_COLL_BIT   1
`define MRF_IRQ_RETRY_ERR_BIT   2
`define MRF_IRQ_WAKE_BIT        3
`define MRF_IRQ_W               4

// reset values
`define MRF_CTRL_RESET          6'h00
`define MRF_WAKE_EN_RESET       1'b0
`define MRF_IRQ_RESET           4'h0

// frame layout and counts
`define MRF_DA_LAST             16'd5
`define MRF_LEN_HI_POS          16'd12
`define MRF_LEN_LO_POS          16'd13
`define MRF_HDR_LEN             16'd14
`define MRF_MIN_PAYLOAD         16'd46
`define MRF_BROADCAST_REJECT_BYTE          8'hff
`define MRF_MAX_ATTEMPTS        5'd16

// address hash
`define MRF_CRC_INIT            32'hffffffff
`define MRF_CRC_POLY            32'hedb88320
`define MRF_HASH_LSB            26

`endif
